/* design/ciois_pkg.sv */
// package: register addresses, field positions and reset values
package ciois_pkg;
    // register addresses on the command port
    localparam logic [4:0] CIOIS_ADDR_IMASK = 5'h11;
    localparam logic [4:0] CIOIS_ADDR_PMASK = 5'h12;
    localparam logic [4:0] CIOIS_ADDR_IODATA = 5'h13;
    localparam logic [4:0] CIOIS_ADDR_SRC = 5'h14;
    // interrupt source field positions
    localparam int CIOIS_BIT_GKP = 0;
    localparam int CIOIS_BIT_RAMP = 1;
    localparam int CIOIS_BIT_OVER_TEMPERATURE_FLAG = 2;
    localparam int CIOIS_BIT_TONE = 3;
    localparam int CIOIS_BIT_LM = 4;
    // interrupt mask field positions (reserved bits kept as stored)
    localparam int CIOIS_MBIT_GKP = 0;
    localparam int CIOIS_MBIT_RAMP = 1;
    localparam int CIOIS_MBIT_OVER_TEMPERATURE_FLAG = 2;
    // reset values
    localparam logic [7:0] CIOIS_RST_IMASK = 8'hFF;
    localparam logic [7:0] CIOIS_RST_PMASK = 8'h0F;
    localparam logic [3:0] CIOIS_RST_DIR = 4'h0;
    localparam logic [3:0] CIOIS_RST_OUT = 4'h0;
    localparam logic CIOIS_RST_GKP = 1'b1;

    // command port request
    typedef struct packed {
        logic valid;
        logic write;
        logic [4:0] addr;
        logic [7:0] wdata;
    } ciois_req_t;

    // status inputs from analog units
    typedef struct packed {
        logic feed_i;
        logic feed_v;
        logic feed_r;
        logic level_meter_done;
        logic tone_detected_flag;
        logic over_temperature_flag;
        logic ramp_done;
        logic ramp_start;
        logic ground_key_polarity;
    } ciois_stat_t;
endpackage : ciois_pkg

/* design/ciois_core.sv */
// channel IO pins and interrupt source status with read-to-clear
`timescale 1ns/1ns
module ciois_core
    import ciois_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire ciois_req_t req,
    input wire ciois_stat_t stat,
    input wire logic [3:0] pin_in,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe,
    output logic [7:0] rdata,
    output logic rvalid,
    output logic irq
);
    logic [7:0] imask_q;
    logic [7:0] pmask_q;
    logic [3:0] dir_q;
    logic [3:0] out_q;
    logic [3:0] pin_prev_q;
    logic [3:0] pin_pend_q;
    logic [4:0] src_prev_q;
    logic [4:0] src_pend_q;
    logic ramp_q;
    logic [7:0] rdata_q;
    logic rvalid_q;

    // command decode
    wire rd = req.valid && !req.write;
    wire wr = req.valid && req.write;
    wire rd_io = rd && req.addr == CIOIS_ADDR_IODATA;
    wire rd_src = rd && req.addr == CIOIS_ADDR_SRC;
    wire wr_io = wr && req.addr == CIOIS_ADDR_IODATA;
    wire wr_im = wr && req.addr == CIOIS_ADDR_IMASK;
    wire wr_pm = wr && req.addr == CIOIS_ADDR_PMASK;

    // data seen per pin: sensed level for inputs, driven level for outputs
    wire [3:0] io_view = (dir_q & out_q) | (~dir_q & pin_in);

    // current source word, bit 7 down to bit 0
    wire [7:0] src_now = {stat.feed_i, stat.feed_v, stat.feed_r,
                          stat.level_meter_done, stat.tone_detected_flag,
                          stat.over_temperature_flag, ramp_q,
                          stat.ground_key_polarity};
    wire [4:0] src_low = src_now[4:0];

    // pin change events, inputs only and unmasked
    wire [3:0] pin_ev = (pin_in ^ pin_prev_q) & ~dir_q
                        & ~pmask_q[3:0];

    // source events: rising edges, polarity any edge; feed flags excluded
    wire [4:0] rise = src_low & ~src_prev_q;
    wire [4:0] src_ev;
    assign src_ev[CIOIS_BIT_LM] = rise[CIOIS_BIT_LM];
    assign src_ev[CIOIS_BIT_TONE] = rise[CIOIS_BIT_TONE];
    assign src_ev[CIOIS_BIT_OVER_TEMPERATURE_FLAG] = rise[CIOIS_BIT_OVER_TEMPERATURE_FLAG]
        && !imask_q[CIOIS_MBIT_OVER_TEMPERATURE_FLAG];
    assign src_ev[CIOIS_BIT_RAMP] = rise[CIOIS_BIT_RAMP]
        && !imask_q[CIOIS_MBIT_RAMP];
    assign src_ev[CIOIS_BIT_GKP] = (src_low[CIOIS_BIT_GKP]
        ^ src_prev_q[CIOIS_BIT_GKP]) && !imask_q[CIOIS_MBIT_GKP];

    // pending: a new event in the clearing cycle wins over the clear
    wire [3:0] pin_pend_d = (rd_io ? 4'h0 : pin_pend_q) | pin_ev;
    wire [4:0] src_pend_d = (rd_src ? 5'h00 : src_pend_q) | src_ev;

    // read mux: unmapped addresses read zero
    wire [7:0] rmux = rd_io ? {dir_q, io_view} :
                      rd_src ? src_now :
                      (req.addr == CIOIS_ADDR_IMASK) ? imask_q :
                      (req.addr == CIOIS_ADDR_PMASK) ? pmask_q : 8'h00;

    // ramp done latches on completion, drops when a new ramp starts
    wire ramp_d = stat.ramp_start ? 1'b0
                  : (ramp_q | stat.ramp_done);

    // configuration registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            imask_q <= CIOIS_RST_IMASK;
            pmask_q <= CIOIS_RST_PMASK;
            dir_q <= CIOIS_RST_DIR;
            out_q <= CIOIS_RST_OUT;
        end else begin
            if (wr_im) imask_q <= req.wdata;
            if (wr_pm) pmask_q <= req.wdata;
            if (wr_io) begin
                dir_q <= req.wdata[7:4];
                out_q <= req.wdata[3:0];
            end
        end
    end

    // history and pending state
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_prev_q <= 4'h0;
            src_prev_q <= {4'h0, CIOIS_RST_GKP};
            pin_pend_q <= 4'h0;
            src_pend_q <= 5'h00;
            ramp_q <= 1'b0;
        end else begin
            pin_prev_q <= pin_in;
            src_prev_q <= src_low;
            pin_pend_q <= pin_pend_d;
            src_pend_q <= src_pend_d;
            ramp_q <= ramp_d;
        end
    end

    // read data registered, one cycle after the request
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rd ? rmux : rdata_q;
            rvalid_q <= rd;
        end
    end

    assign rdata = rdata_q;
    assign rvalid = rvalid_q;
    assign pin_out = out_q;
    assign pin_oe = dir_q;
    assign irq = |pin_pend_q || |src_pend_q;

    // assertions: pin change interrupts and their clearing
    pin_irq_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        (pin_ev != 4'h0) |=> irq)
        else $error("pin change did not raise irq");
    pin_quiet_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        (pmask_q[3:0] | dir_q) == 4'hF && pin_pend_q == 4'h0
        |=> pin_pend_q == 4'h0)
        else $error("masked or output pin raised a pin interrupt");
    io_clear_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        rd_io && pin_ev == 4'h0 |=> pin_pend_q == 4'h0)
        else $error("io read did not clear pin pending");

    // source interrupts: edges, masks and read-to-clear
    src_clear_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        rd_src && src_ev == 5'h00 |=> src_pend_q == 5'h00)
        else $error("source read did not clear pending");
    lm_irq_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        $rose(stat.level_meter_done) |-> ##1 irq)
        else $error("level meter done did not interrupt");
    tone_irq_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        $rose(stat.tone_detected_flag) |-> ##1 irq)
        else $error("tone detect did not interrupt");
    over_temperature_flag_mask_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        $rose(stat.over_temperature_flag) && !imask_q[CIOIS_MBIT_OVER_TEMPERATURE_FLAG]
        |=> src_pend_q[CIOIS_BIT_OVER_TEMPERATURE_FLAG])
        else $error("over temperature did not pend");
    // a masked cause must stay silent, or a user sees stray interrupts
    over_temperature_flag_quiet_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        imask_q[CIOIS_MBIT_OVER_TEMPERATURE_FLAG] && !src_pend_q[CIOIS_BIT_OVER_TEMPERATURE_FLAG]
        |=> !src_pend_q[CIOIS_BIT_OVER_TEMPERATURE_FLAG])
        else $error("masked over temperature still pended");
    gkp_edge_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        $changed(stat.ground_key_polarity) && !imask_q[CIOIS_MBIT_GKP]
        |=> src_pend_q[CIOIS_BIT_GKP])
        else $error("polarity change did not pend");
    ramp_start_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        stat.ramp_start |=> !ramp_q)
        else $error("ramp done not cleared on start");
    ramp_pend_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        $rose(ramp_q) && !imask_q[CIOIS_MBIT_RAMP]
        |=> src_pend_q[CIOIS_BIT_RAMP])
        else $error("ramp completion did not pend");

    // a pending cause holds irq until its own read
    irq_level_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        irq && !rd_io && !rd_src |=> irq)
        else $error("irq dropped without a clearing read");

    // read answers: one-cycle rvalid and the fields of the io and source registers
    rvalid_pulse_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        rd |=> rvalid)
        else $error("read not answered next cycle");
    rvalid_idle_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        !rd |=> !rvalid)
        else $error("rvalid without a read");
    src_feed_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        rd_src |=> rdata[7:5]
        == $past({stat.feed_i, stat.feed_v, stat.feed_r}))
        else $error("feed zone flags misreported");
    src_flags_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        rd_src |=> rdata[4:0] == $past({stat.level_meter_done,
        stat.tone_detected_flag, stat.over_temperature_flag, ramp_q,
        stat.ground_key_polarity}))
        else $error("source flags misreported");
    io_dir_read_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        rd_io |=> rdata[7:4] == pin_oe)
        else $error("direction bits misreported");
    // only one request per cycle, so the direction cannot move under a read
    io_data_read_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        rd_io |=> rdata[3:0]
        == ((pin_out & pin_oe) | ($past(pin_in) & ~pin_oe)))
        else $error("io data bits misreported");

    // writes reach the pins on the next edge
    out_drive_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        wr_io |=> pin_oe == $past(req.wdata[7:4])
        && pin_out == $past(req.wdata[3:0]))
        else $error("io write not applied to pins");
endmodule : ciois_core

/* tb/channel_io_and_interrupt_status_tb.sv */
// self-checking bench for the channel io and interrupt source block
`timescale 1ns/1ns
module channel_io_and_interrupt_status_tb;
    import ciois_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    ciois_req_t req = '0;
    ciois_stat_t stat = 9'h001;
    logic [3:0] pin_in = 4'h0;
    logic [3:0] pin_out;
    logic [3:0] pin_oe;
    logic [7:0] rdata;
    logic rvalid;
    logic irq;
    int mismatches = 0;
    int checks_done = 0;
    logic [31:0] seed = 32'hA342;
    // bench model state, written from the register description
    logic [3:0] m_dir = 4'h0;
    logic [3:0] m_out = 4'h0;
    logic m_ramp = 1'b0;
    logic [7:0] m_imask = 8'hFF;
    logic [7:0] m_pmask = 8'h0F;

    ciois_core DUT (.ref_clk(ref_clk), .rst(rst), .req(req), .stat(stat),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .rdata(rdata), .rvalid(rvalid), .irq(irq));

    // free-running 20 MHz clock
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    function automatic logic [7:0] src_exp();
        return {stat.feed_i, stat.feed_v, stat.feed_r, stat.level_meter_done,
            stat.tone_detected_flag, stat.over_temperature_flag, m_ramp,
            stat.ground_key_polarity};
    endfunction : src_exp

    // outputs show the written bit, inputs show the sensed level
    function automatic logic [7:0] io_exp();
        return {m_dir, (m_dir & m_out) | (~m_dir & pin_in)};
    endfunction : io_exp

    task automatic wrap_up();
        if (mismatches == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    // every drive lands 1 ns after a rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc

    task automatic cmd(input logic wr, input logic [4:0] a,
            input logic [7:0] d);
        req = '{1'b1, wr, a, d};
        cyc(1);
        req.valid = 1'b0;
        if (!wr) cmp({7'h0, rvalid}, 8'h01);
        // one idle edge, so valid never drops and rises in one time step
        cyc(1);
        if (!wr) cmp({7'h0, rvalid}, 8'h00);
    endtask : cmd

    task automatic rd(input logic [4:0] a, input logic [7:0] exp);
        cmd(1'b0, a, 8'h00);
        cmp(rdata, exp);
    endtask : rd

    // wait for an event, check irq, then a source read must drop it
    task automatic ev(input logic e);
        cyc(3);
        cmp({7'h0, irq}, {7'h0, e});
        rd(CIOIS_ADDR_SRC, src_exp());
        cyc(1);
        cmp({7'h0, irq}, 8'h00);
    endtask : ev

    // hang guard: whole sequence needs well under 2000 cycles
    initial begin
        #100000;
        mismatches++;
        wrap_up();
    end

    initial begin
        cyc(3);
        rst = 1'b0;
        cyc(2);
        cmp({7'h0, irq}, 8'h00);
        rd(CIOIS_ADDR_SRC, src_exp());
        rd(CIOIS_ADDR_IODATA, io_exp());
        rd(5'h1F, 8'h00);
        rd(CIOIS_ADDR_PMASK, m_pmask);
        rd(CIOIS_ADDR_IMASK, m_imask);
        // random direction and level writes; pin masks still at reset
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            pin_in = seed[3:0];
            {m_dir, m_out} = seed[11:4];
            cmd(1'b1, CIOIS_ADDR_IODATA, {m_dir, m_out});
            cmp({pin_oe, pin_out}, {m_dir, m_out});
            rd(CIOIS_ADDR_IODATA, io_exp());
        end
        cmp({7'h0, irq}, 8'h00);
        // unmask pins, all inputs, flush history then toggle one pin
        m_dir = 4'h0;
        m_pmask = 8'h00;
        cmd(1'b1, CIOIS_ADDR_PMASK, m_pmask);
        rd(CIOIS_ADDR_PMASK, m_pmask);
        cmd(1'b1, CIOIS_ADDR_IODATA, {m_dir, m_out});
        cyc(2);
        rd(CIOIS_ADDR_IODATA, io_exp());
        pin_in[2] = ~pin_in[2];
        cyc(3);
        cmp({7'h0, irq}, 8'h01);
        rd(CIOIS_ADDR_SRC, src_exp());
        cmp({7'h0, irq}, 8'h01);
        rd(CIOIS_ADDR_IODATA, io_exp());
        cyc(1);
        cmp({7'h0, irq}, 8'h00);
        // an output pin moving on the wire raises nothing
        m_dir = 4'h1;
        cmd(1'b1, CIOIS_ADDR_IODATA, {m_dir, m_out});
        cyc(2);
        rd(CIOIS_ADDR_IODATA, io_exp());
        pin_in[0] = ~pin_in[0];
        cyc(3);
        cmp({7'h0, irq}, 8'h00);
        // unmaskable sources interrupt with every mask set
        stat.level_meter_done = 1'b1;
        ev(1'b1);
        stat.tone_detected_flag = 1'b1;
        ev(1'b1);
        stat.over_temperature_flag = 1'b1;
        ev(1'b0);
        stat.over_temperature_flag = 1'b0;
        ev(1'b0);
        stat.feed_v = 1'b1;
        ev(1'b0);
        m_imask = 8'h00;
        cmd(1'b1, CIOIS_ADDR_IMASK, m_imask);
        rd(CIOIS_ADDR_IMASK, m_imask);
        stat.over_temperature_flag = 1'b1;
        ev(1'b1);
        stat.over_temperature_flag = 1'b0;
        ev(1'b0);
        stat.ramp_done = 1'b1;
        cyc(1);
        stat.ramp_done = 1'b0;
        m_ramp = 1'b1;
        ev(1'b1);
        stat.ramp_start = 1'b1;
        cyc(1);
        stat.ramp_start = 1'b0;
        m_ramp = 1'b0;
        ev(1'b0);
        stat.ground_key_polarity = 1'b0;
        ev(1'b1);
        stat.ground_key_polarity = 1'b1;
        ev(1'b1);
        // mid-run reset: analog flags quiet, every register to default
        rst = 1'b1;
        stat = 9'h001;
        {m_dir, m_out, m_ramp} = 9'h000;
        m_imask = 8'hFF;
        m_pmask = 8'h0F;
        cyc(3);
        rst = 1'b0;
        cyc(2);
        cmp({pin_oe, pin_out}, 8'h00);
        cmp({7'h0, irq}, 8'h00);
        rd(CIOIS_ADDR_PMASK, m_pmask);
        rd(CIOIS_ADDR_IMASK, m_imask);
        rd(CIOIS_ADDR_IODATA, io_exp());
        rd(CIOIS_ADDR_SRC, src_exp());
        wrap_up();
    end
endmodule : channel_io_and_interrupt_status_tb
